// *** sdei_pkg.sv ***
// Purpose: constants and types for the switch drop-event interrupt block
// Assumes: word-indexed register port, one clock
// Notes: offsets are register indices as printed
package sdei_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [15:0] LEARN_MISS_OFS = 16'h185a;
	localparam logic [15:0] IRQ_MASK_OFS = 16'h1880;
	localparam logic [15:0] DROP_STATUS_OFS = 16'h1881;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [31:0] LEARN_MISS_RST = 32'h0000_0000;
	localparam logic [31:0] LEARN_MISS_MAX = 32'hffff_ffff;
	localparam logic MASK_RST = 1'b1;
	localparam int MASK_BIT = 0;
	localparam int PEND_BIT = 0;
	localparam int A_VALID_BIT = 1;
	localparam int A_PORT_LSB = 2;
	localparam int A_REASON_LSB = 4;
	localparam int B_VALID_BIT = 8;
	localparam int B_PORT_LSB = 9;
	localparam int B_REASON_LSB = 11;

	// ----------------------------------------
	// drop reasons
	// ----------------------------------------
	localparam logic [3:0] RSN_TAGGED_ONLY = 4'h0;
	localparam logic [3:0] RSN_UNK_SRC_NONMEMBER = 4'h1;
	localparam logic [3:0] RSN_KNOWN_SRC_NOFWD = 4'h2;
	localparam logic [3:0] RSN_KNOWN_DST_NOFWD = 4'h3;
	localparam logic [3:0] RSN_DST_NONMEMBER = 4'h4;
	localparam logic [3:0] RSN_SRC_NONMEMBER = 4'h5;
	localparam logic [3:0] RSN_UNK_UNICAST = 4'h6;
	localparam logic [3:0] RSN_UNK_MULTICAST = 4'h7;
	localparam logic [3:0] RSN_BCAST_THROTTLE = 4'h8;
	localparam logic [3:0] RSN_UNK_SRC_NOFWD = 4'h9;
	localparam logic [3:0] RSN_SAME_PORT = 4'ha;
	localparam logic [3:0] RSN_FILTER_ENTRY = 4'hb;
	localparam logic [3:0] RSN_VID_ALL_ONES = 4'he;
	localparam logic [1:0] PORT_RESERVED = 2'h3;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] reason;
		logic [1:0] port;
	} sdei_drop_t;

	typedef struct packed {
		logic valid;
		sdei_drop_t drop;
	} sdei_capture_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sdei_req_t;

endpackage

// *** sdei_drop_irq.sv ***
// Purpose: drop-event capture, engine interrupt and port 2 learn-miss count
// Assumes: inputs synchronous to clock; strobes one cycle, never together
// Notes: read data stands in the cycle after the read strobe only
//
// Notes on behaviour
// - keep a 32-bit count of port 2 addresses not learned for lack of space
// - reading the counter returns its value then zeroes it, or sets it to one if an event lands in the read cycle; reset zeroes it
// - the counter stops at all ones and never wraps
// - mask bit 0 blocks the engine interrupt while set; resets to one
// - clearing the mask unmasks; masking never alters the status bits
// - two capture sets, A then B, each record one drop; B fills only while A holds one
// - bit 0 pending set on any drop with a legal reason and port, cleared by reading, resets zero
// - bit 1 flags set A holds a drop, bits 7:2 valid; clears on read
// - set A reason sits in bits 7:4, cleared on read
// - set A source port in bits 3:2, cleared on read; 11 reserved
// - bit 8 flags set B holds a drop, bits 14:9 valid; clears on read
// - set B reason in bits 14:11, port in bits 10:9, cleared on read
// - reasons 0000 tagged-only admit, 0001 unknown dest source non-member
// - reasons 0010 known dest, source not fwd; 0011 dest not fwd
// - reasons 0100 dest non-member, 0101 source non-member, known dest
// - reasons 0110 unknown unicast drop, 0111 unknown multicast filter
// - reasons 1000 broadcast throttled, 1001 unknown dest, source not fwd
// - reasons 1010 same port, 1011 table entry filter flag
// - reason 1110 all-ones VLAN id; 1100, 1101, 1111 never reported
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module sdei_drop_irq (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic drop_valid,
	input wire logic [3:0] drop_reason,
	input wire logic [1:0] drop_port,
	input wire logic learn_miss,
	output logic engine_irq
);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	sdei_pkg::sdei_req_t req;
	sdei_pkg::sdei_drop_t drop_in;
	logic drop_ok;
	logic rd_status;
	logic rd_count;
	logic wr_mask;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign drop_in = '{reason: drop_reason, port: drop_port};

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// reserved codes are not reported; such a drop is ignored outright
	function automatic logic reason_legal(input logic [3:0] r);
		unique case (r)
			sdei_pkg::RSN_TAGGED_ONLY, sdei_pkg::RSN_UNK_SRC_NONMEMBER,
			sdei_pkg::RSN_KNOWN_SRC_NOFWD, sdei_pkg::RSN_KNOWN_DST_NOFWD,
			sdei_pkg::RSN_DST_NONMEMBER, sdei_pkg::RSN_SRC_NONMEMBER,
			sdei_pkg::RSN_UNK_UNICAST, sdei_pkg::RSN_UNK_MULTICAST,
			sdei_pkg::RSN_BCAST_THROTTLE, sdei_pkg::RSN_UNK_SRC_NOFWD,
			sdei_pkg::RSN_SAME_PORT, sdei_pkg::RSN_FILTER_ENTRY,
			sdei_pkg::RSN_VID_ALL_ONES: reason_legal = 1'b1;
			default: reason_legal = 1'b0;
		endcase
	endfunction

	assign drop_ok = drop_valid && reason_legal(drop_in.reason) &&
		(drop_in.port != sdei_pkg::PORT_RESERVED);
	assign rd_status = clk_en && req.rd &&
		hit(req.addr, sdei_pkg::DROP_STATUS_OFS);
	assign rd_count = clk_en && req.rd &&
		hit(req.addr, sdei_pkg::LEARN_MISS_OFS);
	assign wr_mask = clk_en && req.wr &&
		hit(req.addr, sdei_pkg::IRQ_MASK_OFS);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] learn_cnt_r;
	logic mask_r;
	logic pend_r;
	sdei_pkg::sdei_capture_t cap_a_r;
	sdei_pkg::sdei_capture_t cap_b_r;
	logic [31:0] status_word;

	function automatic logic [31:0] pack_status(input logic p,
		input sdei_pkg::sdei_capture_t a, input sdei_pkg::sdei_capture_t b);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[sdei_pkg::PEND_BIT] = p;
		w[sdei_pkg::A_VALID_BIT] = a.valid;
		w[sdei_pkg::A_PORT_LSB +: 2] = a.drop.port;
		w[sdei_pkg::A_REASON_LSB +: 4] = a.drop.reason;
		w[sdei_pkg::B_VALID_BIT] = b.valid;
		w[sdei_pkg::B_PORT_LSB +: 2] = b.drop.port;
		w[sdei_pkg::B_REASON_LSB +: 4] = b.drop.reason;
		pack_status = w;
	endfunction

	assign status_word = pack_status(pend_r, cap_a_r, cap_b_r);

	// ----------------------------------------
	// learn-miss counter
	// ----------------------------------------
	// an increment landing in the cycle of the read is kept as the new count
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			learn_cnt_r <= sdei_pkg::LEARN_MISS_RST;
		end else if (clk_en) begin
			if (rd_count) begin
				learn_cnt_r <= {31'h0000_0000, learn_miss};
			end else if (learn_miss && learn_cnt_r != sdei_pkg::LEARN_MISS_MAX) begin
				learn_cnt_r <= learn_cnt_r + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------
	// mask register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= sdei_pkg::MASK_RST;
		end else if (wr_mask) begin
			mask_r <= req.wdata[sdei_pkg::MASK_BIT];
		end
	end

	// ----------------------------------------
	// pending flag
	// ----------------------------------------
	// a drop in the read cycle wins, so no event is lost; mask never touches it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
		end else if (clk_en) begin
			if (drop_ok) begin
				pend_r <= 1'b1;
			end else if (rd_status) begin
				pend_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// capture sets
	// ----------------------------------------
	// a drop arriving with the read lands in the freshly freed set A
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap_a_r <= '0;
		end else if (clk_en) begin
			if (drop_ok && (!cap_a_r.valid || rd_status)) begin
				cap_a_r <= '{valid: 1'b1, drop: drop_in};
			end else if (rd_status) begin
				cap_a_r <= '0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap_b_r <= '0;
		end else if (clk_en) begin
			if (drop_ok && cap_a_r.valid && !cap_b_r.valid && !rd_status) begin
				cap_b_r <= '{valid: 1'b1, drop: drop_in};
			end else if (rd_status) begin
				cap_b_r <= '0;
			end
		end
	end

	// ----------------------------------------
	// read data and interrupt
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (req.rd) begin
				if (hit(req.addr, sdei_pkg::LEARN_MISS_OFS)) begin
					reg_rdata <= learn_cnt_r;
				end else if (hit(req.addr, sdei_pkg::IRQ_MASK_OFS)) begin
					reg_rdata <= {31'h0000_0000, mask_r};
				end else if (hit(req.addr, sdei_pkg::DROP_STATUS_OFS)) begin
					reg_rdata <= status_word;
				end else begin
					reg_rdata <= 32'h0000_0000;
				end
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end
	end

	// registered, so the interrupt trails pending and mask by one cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			engine_irq <= 1'b0;
		end else if (clk_en) begin
			engine_irq <= pend_r && !mask_r;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	count_sat_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && learn_cnt_r == sdei_pkg::LEARN_MISS_MAX && !rd_count
		|=> learn_cnt_r == sdei_pkg::LEARN_MISS_MAX)
		else $error("learn-miss counter wrapped");

	count_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_count && !learn_miss |=> learn_cnt_r == 32'h0000_0000)
		else $error("learn-miss counter not cleared by read");

	count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && learn_miss && !rd_count &&
		learn_cnt_r != sdei_pkg::LEARN_MISS_MAX
		|=> learn_cnt_r == $past(learn_cnt_r) + 32'h0000_0001)
		else $error("learn-miss counter missed an increment");

	irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en |=> engine_irq == ($past(pend_r) && !$past(mask_r)))
		else $error("engine interrupt not pending and unmasked");

	mask_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_mask && !drop_ok && !rd_status |=> pend_r == $past(pend_r))
		else $error("mask write altered pending");

	fill_a_first_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && drop_ok && !cap_a_r.valid
		|=> cap_a_r.valid && cap_a_r.drop == $past(drop_in) && pend_r)
		else $error("drop not captured in set a");

	fill_b_next_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && drop_ok && cap_a_r.valid && !cap_b_r.valid && !rd_status
		|=> cap_b_r.valid && cap_b_r.drop == $past(drop_in) &&
		cap_a_r == $past(cap_a_r))
		else $error("second drop not captured in set b");

	both_full_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && cap_a_r.valid && cap_b_r.valid && !rd_status
		|=> cap_a_r == $past(cap_a_r) && cap_b_r == $past(cap_b_r))
		else $error("full capture set overwritten");

	status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_status && !drop_ok
		|=> !pend_r && !cap_a_r.valid && !cap_b_r.valid &&
		reg_rdata == $past(status_word))
		else $error("status read wrong or not cleared");

	mask_reset_a: assert property (@(posedge clock)
		!rst_n |=> mask_r || !rst_n)
		else $error("mask not set after reset");

	// ----------------------------------------
	// checks: counter and mask
	// ----------------------------------------
	count_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && !learn_miss && !rd_count
		|=> learn_cnt_r == $past(learn_cnt_r))
		else $error("learn-miss counter moved without an event");

	count_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_count |=> reg_rdata == $past(learn_cnt_r))
		else $error("learn-miss read returned wrong value");

	count_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_count && learn_miss |=> learn_cnt_r == 32'h0000_0001)
		else $error("event beside counter read was lost");

	count_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> learn_cnt_r == $past(learn_cnt_r))
		else $error("learn-miss counter moved while frozen");

	mask_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_mask |=> mask_r == $past(req.wdata[sdei_pkg::MASK_BIT]))
		else $error("mask write not taken");

	mask_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_mask |=> mask_r == $past(mask_r))
		else $error("mask changed without a write");

	mask_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && req.rd && hit(req.addr, sdei_pkg::IRQ_MASK_OFS)
		|=> reg_rdata == {31'h0000_0000, $past(mask_r)})
		else $error("mask read returned wrong value");

	irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && mask_r |=> !engine_irq)
		else $error("engine interrupt raised while masked");

	rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && !req.rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data stood beyond its cycle");

	// ----------------------------------------
	// checks: pending and capture sets
	// ----------------------------------------
	pend_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && drop_ok |=> pend_r)
		else $error("drop did not set pending");

	pend_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && !drop_ok && !rd_status |=> pend_r == $past(pend_r))
		else $error("pending changed without drop or read");

	reserved_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && drop_valid && !drop_ok && !rd_status
		|=> status_word == $past(status_word))
		else $error("reserved drop altered the status");

	read_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_status && drop_ok
		|=> pend_r && cap_a_r.valid && !cap_b_r.valid &&
		cap_a_r.drop == $past(drop_in))
		else $error("drop beside status read was lost");

	state_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> pend_r == $past(pend_r) && mask_r == $past(mask_r) &&
		cap_a_r == $past(cap_a_r) && cap_b_r == $past(cap_b_r) &&
		engine_irq == $past(engine_irq))
		else $error("state moved while frozen");

	port_a_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
		cap_a_r.valid |-> cap_a_r.drop.port != sdei_pkg::PORT_RESERVED &&
		reason_legal(cap_a_r.drop.reason))
		else $error("set a holds a reserved code");

	port_b_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
		cap_b_r.valid |-> cap_b_r.drop.port != sdei_pkg::PORT_RESERVED &&
		reason_legal(cap_b_r.drop.reason))
		else $error("set b holds a reserved code");

	b_after_a_a: assert property (@(posedge clock) disable iff (!rst_n)
		cap_b_r.valid |-> cap_a_r.valid)
		else $error("set b filled before set a");

	valid_pends_a: assert property (@(posedge clock) disable iff (!rst_n)
		cap_a_r.valid |-> pend_r)
		else $error("captured drop without pending");

	irq_source_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && !pend_r |=> !engine_irq)
		else $error("engine interrupt without pending");

endmodule

`default_nettype wire

// *** test_switch_drop_event_irq.sv ***
// Purpose: self-checking bench for the drop-event interrupt block
// Assumes: index register port, one clock, read data one cycle after strobe
// Notes: counter saturation needs 2^32 events and is left to review
`timescale 1ns/100ps
`default_nettype none

module test_switch_drop_event_irq;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic drop_valid = 1'b0;
	logic [3:0] drop_reason = 4'h0;
	logic [1:0] drop_port = 2'h0;
	logic learn_miss = 1'b0;
	logic engine_irq;
	int n_errors = 0;
	int compares = 0;
	// rows: reason, port, expected status word
	logic [13:0] rows [13] = '{
		{4'h0, 2'h0, 8'h03}, {4'h1, 2'h1, 8'h17}, {4'h2, 2'h2, 8'h2b},
		{4'h3, 2'h0, 8'h33}, {4'h4, 2'h1, 8'h47}, {4'h5, 2'h2, 8'h5b},
		{4'h6, 2'h0, 8'h63}, {4'h7, 2'h1, 8'h77}, {4'h8, 2'h2, 8'h8b},
		{4'h9, 2'h0, 8'h93}, {4'ha, 2'h1, 8'ha7}, {4'hb, 2'h2, 8'hbb},
		{4'he, 2'h0, 8'he3}};

	sdei_drop_irq sdei_drop_irq_i (
		.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .drop_valid(drop_valid),
		.drop_reason(drop_reason), .drop_port(drop_port),
		.learn_miss(learn_miss), .engine_irq(engine_irq));

	initial begin
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic drop(input logic [3:0] r, input logic [1:0] p);
		@(posedge clock);
		drop_valid <= 1'b1;
		drop_reason <= r;
		drop_port <= p;
		@(posedge clock);
		drop_valid <= 1'b0;
	endtask

	// irq is registered one cycle behind pending and mask
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clock);
		#1 chk({31'h0, engine_irq}, {31'h0, exp});
	endtask

	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		rd_chk(sdei_pkg::IRQ_MASK_OFS, 32'h0000_0001);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		rd_chk(sdei_pkg::LEARN_MISS_OFS, 32'h0000_0000);
		for (int i = 0; i < 13; i++) begin
			drop(rows[i][13:10], rows[i][9:8]);
			irq_chk(1'b0);
			rd_chk(sdei_pkg::DROP_STATUS_OFS, {24'h0, rows[i][7:0]});
			rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		end
		// both sets filled back to back, third drop only pends
		wr(sdei_pkg::IRQ_MASK_OFS, 32'h0000_0000);
		@(posedge clock);
		drop_valid <= 1'b1;
		drop_reason <= 4'h6;
		drop_port <= 2'h1;
		@(posedge clock);
		drop_reason <= 4'h9;
		drop_port <= 2'h2;
		@(posedge clock);
		drop_reason <= 4'h1;
		drop_port <= 2'h0;
		@(posedge clock);
		drop_valid <= 1'b0;
		irq_chk(1'b1);
		wr(sdei_pkg::IRQ_MASK_OFS, 32'hffff_ffff);
		irq_chk(1'b0);
		rd_chk(sdei_pkg::IRQ_MASK_OFS, 32'h0000_0001);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_4d67);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		// reserved reasons and the reserved port are not reported
		drop(4'hc, 2'h0);
		drop(4'hd, 2'h1);
		drop(4'hf, 2'h2);
		drop(4'he, 2'h3);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		// a frozen clock enable ignores the event
		@(posedge clock);
		clk_en <= 1'b0;
		drop(4'h2, 2'h1);
		clk_en <= 1'b1;
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		// status is read-clear only and unmapped reads give zero
		wr(sdei_pkg::DROP_STATUS_OFS, 32'hffff_ffff);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		rd_chk(16'h1882, 32'h0000_0000);
		// pending survives unmasking; masking leaves it intact
		drop(4'h3, 2'h2);
		irq_chk(1'b0);
		wr(sdei_pkg::IRQ_MASK_OFS, 32'h0000_0000);
		irq_chk(1'b1);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_003b);
		irq_chk(1'b0);
		// learn-miss count, clear on read, event beside the read
		@(posedge clock);
		learn_miss <= 1'b1;
		repeat (5) @(posedge clock);
		learn_miss <= 1'b0;
		rd_chk(sdei_pkg::LEARN_MISS_OFS, 32'h0000_0005);
		rd_chk(sdei_pkg::LEARN_MISS_OFS, 32'h0000_0000);
		@(posedge clock);
		learn_miss <= 1'b1;
		repeat (3) @(posedge clock);
		reg_addr <= sdei_pkg::LEARN_MISS_OFS;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		learn_miss <= 1'b0;
		#1 chk(reg_rdata, 32'h0000_0003);
		rd_chk(sdei_pkg::LEARN_MISS_OFS, 32'h0000_0001);
		// drop beside a status read: old word returned, new drop kept in a
		drop(4'h2, 2'h0);
		@(posedge clock);
		reg_addr <= sdei_pkg::DROP_STATUS_OFS;
		reg_rd <= 1'b1;
		drop_valid <= 1'b1;
		drop_reason <= 4'h7;
		drop_port <= 2'h1;
		@(posedge clock);
		reg_rd <= 1'b0;
		drop_valid <= 1'b0;
		#1 chk(reg_rdata, 32'h0000_0023);
		@(posedge clock);
		#1 chk(reg_rdata, 32'h0000_0000);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0077);
		// second reset in mid-run restores the mask and clears status
		drop(4'h8, 2'h0);
		do_reset();
		rd_chk(sdei_pkg::IRQ_MASK_OFS, 32'h0000_0001);
		rd_chk(sdei_pkg::DROP_STATUS_OFS, 32'h0000_0000);
		irq_chk(1'b0);
		report_and_stop();
	end
endmodule

`default_nettype wire
